/* File: hdl/discovery_reader_defines.svh */
`ifndef DISCOVERY_READER_DEFINES_SVH
`define DISCOVERY_READER_DEFINES_SVH

////////////////////////////////////////////////////////////////////////////////
// Opcodes and phase lengths
`define UNIQUE_NUMBER_READ_OPCODE   8'h4B
`define DISCOVERY_TABLE_READ_OPCODE 8'h5A
`define UNIQUE_DUMMY_BYTES          3'h4
`define TABLE_ADDR_BYTES            3'h3
`define TABLE_DUMMY_BYTES           3'h1
`define UNIQUE_NUMBER_BITS          128
`define UNIQUE_NUMBER_BYTES         5'h10
`define FILL_BYTE                   8'hFF

////////////////////////////////////////////////////////////////////////////////
// Table contents by byte address
`define SIG_B0          8'h53
`define SIG_B1          8'h46
`define SIG_B2          8'h44
`define SIG_B3          8'h50
`define TBL_REV_MINOR   8'h00
`define TBL_REV_MAJOR   8'h01
`define HDR_COUNT       8'h01
`define HDR0_ID         8'h00
`define HDR_REV_MINOR   8'h00
`define HDR_REV_MAJOR   8'h01
`define HDR0_LEN        8'h09
`define HDR0_PTR_LO     8'h30
`define HDR1_LEN        8'h03
`define HDR1_PTR_LO     8'h60
`define PTR_HI          8'h00
`define ERASE_FLAGS     8'hE5
`define ERASE_4K_OPCODE 8'h20
`define READ_MODE_FLAGS 8'hF1
`define DENSITY_LOW     8'hFF
`define DENSITY_TOP     8'h00
`define QIO_WAIT_MODE   8'h44
`define QIO_OPCODE      8'hEB
`define QOUT_WAIT_MODE  8'h08
`define QOUT_OPCODE     8'h6B

`endif

/* File: hdl/discovery_reader_pkg.sv */
package discovery_reader_pkg;

  typedef enum logic [2:0] {
    ST_OPCODE,
    ST_ADDR,
    ST_DUMMY,
    ST_DATA,
    ST_IGNORE
  } phase_t;

  typedef enum logic {
    SRC_UNIQUE,
    SRC_TABLE
  } source_t;

endpackage : discovery_reader_pkg

/* File: hdl/byte_fifo.sv */
`timescale 1ns/1ps
module byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input  wire logic             clk_sys_i,
  input  wire logic             rst_n_i,
  input  wire logic             ce_i,
  input  wire logic             flush_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic      [WIDTH-1:0] out_data_o
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  logic             push;
  logic             pop;

  // Full test at the count's own width; a narrower cast folds DEPTH to zero
  assign in_ready_o  = (count != (AW+1)'(DEPTH)) && !flush_i;
  assign out_valid_o = (count != '0);
  assign out_data_o  = mem[rd_ptr];
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i && !flush_i;

  always_ff @(posedge clk_sys_i) begin
    if (ce_i && push) begin
      mem[wr_ptr] <= in_data_i;
    end
  end

  // Pointers wrap by hand so any depth works
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i || (ce_i && flush_i)) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else if (ce_i) begin
      if (push) begin
        wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      end
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

endmodule : byte_fifo

/* File: hdl/discovery_reader.sv */
`timescale 1ns/1ps
`include "discovery_reader_defines.svh"
// Overview of operation
// - A fixed 128-bit unique number per part; no command changes it.
// - Opcode 4B as first byte after select low starts unique read.
// - Four dummy bytes, then the full unique number out once, then FFH until deselect.
// - Opcode 5Ah then three address bytes pick the first table byte.
// - One dummy byte, then table bytes out like single-line fast read.
// - Deselect at any point in data ends the read and releases output.
// - Bytes 00H to 03H return signature 53H 46H 44H 50H.
// - Byte 04H returns 00H, byte 05H returns 01H.
// - Byte 06H returns 01H: two parameter headers follow.
// - Bytes 07H, 0FH and 17H return fixed FFH.
// - First header: ID 00H, rev 1.0, 09H dwords, pointer 000030H.
// - Second header: vendor ID, rev 1.0, 03H dwords, pointer 000060H.
// - Byte 30H returns E5H; byte 31H returns erase opcode 20H.
// - Byte 32H returns F1H; byte 33H returns FFH.
// - Byte 38H returns 44H; byte 39H returns EBH.
// - Byte 3AH returns 08H; byte 3BH returns 6BH.
module discovery_reader #(
  parameter logic [127:0] UNIQUE_NUMBER = 128'h0123456789ABCDEF_FEDCBA9876543210,
  // Arbitrary vendor identifier, not any real maker's code
  parameter logic [7:0]   VENDOR_ID     = 8'hA5,
  parameter int           FIFO_DEPTH    = 4
) (
  input  wire logic        clk_sys_i,
  input  wire logic        rst_n_i,
  input  wire logic        ce_i,
  input  wire logic        cs_n_i,
  input  wire logic        sck_i,
  input  wire logic        si_i,
  output logic             so_o,
  output logic             so_oe_o,
  output logic             frame_active_o,
  output logic             unique_read_o,
  output logic             table_read_o,
  output logic             unknown_cmd_o,
  output logic [23:0]      table_addr_o
);

  //////////////////////////////////////////////////////////////////////////////
  // Table contents

  function automatic logic [7:0] table_byte(input logic [23:0] addr,
                                            input logic [7:0]  vid);
    logic [7:0] b;
    b = `FILL_BYTE;
    if (addr[23:8] == 16'h0000) begin
      unique case (addr[7:0])
        8'h00:   b = `SIG_B0;
        8'h01:   b = `SIG_B1;
        8'h02:   b = `SIG_B2;
        8'h03:   b = `SIG_B3;
        8'h04:   b = `TBL_REV_MINOR;
        8'h05:   b = `TBL_REV_MAJOR;
        8'h06:   b = `HDR_COUNT;
        8'h07:   b = `FILL_BYTE;
        8'h08:   b = `HDR0_ID;
        8'h09:   b = `HDR_REV_MINOR;
        8'h0A:   b = `HDR_REV_MAJOR;
        8'h0B:   b = `HDR0_LEN;
        8'h0C:   b = `HDR0_PTR_LO;
        8'h0D:   b = `PTR_HI;
        8'h0E:   b = `PTR_HI;
        8'h0F:   b = `FILL_BYTE;
        8'h10:   b = vid;
        8'h11:   b = `HDR_REV_MINOR;
        8'h12:   b = `HDR_REV_MAJOR;
        8'h13:   b = `HDR1_LEN;
        8'h14:   b = `HDR1_PTR_LO;
        8'h15:   b = `PTR_HI;
        8'h16:   b = `PTR_HI;
        8'h17:   b = `FILL_BYTE;
        8'h30:   b = `ERASE_FLAGS;
        8'h31:   b = `ERASE_4K_OPCODE;
        8'h32:   b = `READ_MODE_FLAGS;
        8'h33:   b = `FILL_BYTE;
        8'h34:   b = `DENSITY_LOW;
        8'h35:   b = `DENSITY_LOW;
        8'h36:   b = `DENSITY_LOW;
        8'h37:   b = `DENSITY_TOP;
        8'h38:   b = `QIO_WAIT_MODE;
        8'h39:   b = `QIO_OPCODE;
        8'h3A:   b = `QOUT_WAIT_MODE;
        8'h3B:   b = `QOUT_OPCODE;
        default: b = `FILL_BYTE;
      endcase
    end
    return b;
  endfunction : table_byte

  //////////////////////////////////////////////////////////////////////////////
  // Serial clock edges, pins already synchronous to clk_sys_i

  discovery_reader_pkg::phase_t  phase;
  discovery_reader_pkg::source_t source;

  logic        sck_q;
  logic        sck_rise;
  logic        sck_fall;
  logic [2:0]  bit_cnt;
  logic [2:0]  byte_cnt;
  logic [7:0]  in_sr;
  logic [7:0]  next_in_byte;
  logic        byte_done;
  logic [23:0] fetch_addr;
  logic [4:0]  uid_idx;
  logic [7:0]  fetch_byte;
  logic        fill_en;
  logic        fifo_in_ready;
  logic        fifo_out_valid;
  logic        fifo_pop;
  logic [7:0]  fifo_out_data;
  logic [7:0]  out_sr;
  logic [2:0]  out_cnt;

  assign sck_rise     = sck_i && !sck_q && !cs_n_i;
  assign sck_fall     = !sck_i && sck_q && !cs_n_i;
  assign next_in_byte = {in_sr[6:0], si_i};
  assign byte_done    = sck_rise && (bit_cnt == 3'h7);

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      sck_q <= 1'b0;
    end else if (ce_i) begin
      sck_q <= sck_i;
    end
  end

  // Input shift and bit counting on rising serial clock
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      in_sr   <= 8'h00;
      bit_cnt <= 3'h0;
    end else if (ce_i) begin
      if (cs_n_i) begin
        bit_cnt <= 3'h0;
      end else if (sck_rise) begin
        in_sr   <= next_in_byte;
        bit_cnt <= bit_cnt + 3'h1;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Command phase sequencing

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      phase    <= discovery_reader_pkg::ST_OPCODE;
      source   <= discovery_reader_pkg::SRC_TABLE;
      byte_cnt <= 3'h0;
    end else if (ce_i) begin
      if (cs_n_i) begin
        phase    <= discovery_reader_pkg::ST_OPCODE;
        byte_cnt <= 3'h0;
      end else if (byte_done) begin
        byte_cnt <= byte_cnt + 3'h1;
        unique case (phase)
          discovery_reader_pkg::ST_OPCODE: begin
            byte_cnt <= 3'h0;
            if (next_in_byte == `UNIQUE_NUMBER_READ_OPCODE) begin
              source <= discovery_reader_pkg::SRC_UNIQUE;
              phase  <= discovery_reader_pkg::ST_DUMMY;
            end else if (next_in_byte == `DISCOVERY_TABLE_READ_OPCODE) begin
              source <= discovery_reader_pkg::SRC_TABLE;
              phase  <= discovery_reader_pkg::ST_ADDR;
            end else begin
              // Other commands belong to other blocks
              phase <= discovery_reader_pkg::ST_IGNORE;
            end
          end
          discovery_reader_pkg::ST_ADDR: begin
            if (byte_cnt == `TABLE_ADDR_BYTES - 3'h1) begin
              byte_cnt <= 3'h0;
              phase    <= discovery_reader_pkg::ST_DUMMY;
            end
          end
          discovery_reader_pkg::ST_DUMMY: begin
            if ((source == discovery_reader_pkg::SRC_UNIQUE &&
                 byte_cnt == `UNIQUE_DUMMY_BYTES - 3'h1) ||
                (source == discovery_reader_pkg::SRC_TABLE &&
                 byte_cnt == `TABLE_DUMMY_BYTES - 3'h1)) begin
              byte_cnt <= 3'h0;
              phase    <= discovery_reader_pkg::ST_DATA;
            end
          end
          discovery_reader_pkg::ST_DATA,
          discovery_reader_pkg::ST_IGNORE: begin
            byte_cnt <= 3'h0;
          end
        endcase
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Byte fetch into the FIFO; prefill starts in the dummy phase so the
  // first data bit never waits on a lookup

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      fetch_addr <= 24'h000000;
      uid_idx    <= 5'h00;
    end else if (ce_i) begin
      if (cs_n_i) begin
        uid_idx <= 5'h00;
      end else if (phase == discovery_reader_pkg::ST_ADDR && sck_rise) begin
        fetch_addr <= {fetch_addr[22:0], si_i};
      end else if (fill_en && fifo_in_ready) begin
        if (source == discovery_reader_pkg::SRC_TABLE) begin
          fetch_addr <= fetch_addr + 24'h000001;
        end else if (uid_idx != `UNIQUE_NUMBER_BYTES) begin
          uid_idx <= uid_idx + 5'h01;
        end
      end
    end
  end

  assign fill_en = !cs_n_i && (phase == discovery_reader_pkg::ST_DUMMY ||
                               phase == discovery_reader_pkg::ST_DATA);

  // Unique number goes out most significant byte first; past its end the
  // line idles high rather than wrapping
  always_comb begin
    fetch_byte = `FILL_BYTE;
    if (source == discovery_reader_pkg::SRC_TABLE) begin
      fetch_byte = table_byte(fetch_addr, VENDOR_ID);
    end else if (uid_idx != `UNIQUE_NUMBER_BYTES) begin
      fetch_byte = UNIQUE_NUMBER[(15 - 32'(uid_idx)) * 8 +: 8];
    end
  end

  byte_fifo #(
    .WIDTH (8),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_sys_i   (clk_sys_i),
    .rst_n_i     (rst_n_i),
    .ce_i        (ce_i),
    .flush_i     (cs_n_i),
    .in_valid_i  (fill_en),
    .in_ready_o  (fifo_in_ready),
    .in_data_i   (fetch_byte),
    .out_valid_o (fifo_out_valid),
    .out_ready_i (fifo_pop),
    .out_data_o  (fifo_out_data)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Output shifter, changes on falling serial clock

  assign fifo_pop = sck_fall && (phase == discovery_reader_pkg::ST_DATA) &&
                    (out_cnt == 3'h0);

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      so_o    <= 1'b1;
      so_oe_o <= 1'b0;
      out_sr  <= 8'h00;
      out_cnt <= 3'h0;
    end else if (ce_i) begin
      so_oe_o <= !cs_n_i && (phase == discovery_reader_pkg::ST_DATA);
      if (cs_n_i || phase != discovery_reader_pkg::ST_DATA) begin
        out_cnt <= 3'h0;
        so_o    <= 1'b1;
      end else if (sck_fall) begin
        if (out_cnt == 3'h0) begin
          // An empty FIFO cannot occur at legal clock rates; send ones
          so_o    <= fifo_out_valid ? fifo_out_data[7] : 1'b1;
          out_sr  <= fifo_out_valid ? {fifo_out_data[6:0], 1'b0} : 8'hFF;
          out_cnt <= 3'h7;
        end else begin
          so_o    <= out_sr[7];
          out_sr  <= {out_sr[6:0], 1'b0};
          out_cnt <= out_cnt - 3'h1;
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Status outputs

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      frame_active_o <= 1'b0;
      unique_read_o  <= 1'b0;
      table_read_o   <= 1'b0;
      unknown_cmd_o  <= 1'b0;
      table_addr_o   <= 24'h000000;
    end else if (ce_i) begin
      frame_active_o <= !cs_n_i;
      unique_read_o  <= !cs_n_i && source == discovery_reader_pkg::SRC_UNIQUE
                        && (phase == discovery_reader_pkg::ST_DUMMY ||
                            phase == discovery_reader_pkg::ST_DATA);
      table_read_o   <= !cs_n_i && source == discovery_reader_pkg::SRC_TABLE
                        && (phase == discovery_reader_pkg::ST_ADDR ||
                            phase == discovery_reader_pkg::ST_DUMMY ||
                            phase == discovery_reader_pkg::ST_DATA);
      unknown_cmd_o  <= !cs_n_i && phase == discovery_reader_pkg::ST_IGNORE;
      table_addr_o   <= fetch_addr;
    end
  end

endmodule : discovery_reader

/* File: dv/discovery_reader_assertions.sv */
`timescale 1ns/1ps
module discovery_reader_assertions (
  input wire logic        clk_sys_i,
  input wire logic        rst_n_i,
  input wire logic        cs_n_i,
  input wire logic        sck_i,
  input wire logic        so_o,
  input wire logic        so_oe_o,
  input wire logic        frame_active_o,
  input wire logic        unique_read_o,
  input wire logic        table_read_o,
  input wire logic        unknown_cmd_o,
  input wire logic [23:0] table_addr_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);

  a_oe_off_deselect: assert property (cs_n_i |=> !so_oe_o)
    else $error("output enable held after deselect");
  a_idle_line_high: assert property (!so_oe_o |-> so_o)
    else $error("serial output not high while idle");
  a_ignored_no_drive: assert property (unknown_cmd_o |-> !so_oe_o)
    else $error("output driven for an ignored opcode");
  a_one_command: assert property (
    $onehot0({unique_read_o, table_read_o, unknown_cmd_o}))
    else $error("more than one command flag set");
  a_frame_tracks_cs: assert property (
    1'b1 |=> frame_active_o == !$past(cs_n_i))
    else $error("frame flag does not follow select");
  // Bits may only move while the serial clock is low (mode 0)
  a_bit_on_fall: assert property (
    $changed(so_o) && so_oe_o && $past(so_oe_o) |-> !$past(sck_i))
    else $error("output bit changed outside clock low phase");
  a_addr_steps_one: assert property (
    so_oe_o && $past(so_oe_o) && $changed(table_addr_o)
    |-> table_addr_o == $past(table_addr_o) + 24'h1)
    else $error("table address did not step by one");
  a_oe_needs_read: assert property (
    $rose(so_oe_o) |-> !$past(cs_n_i) && (unique_read_o || table_read_o))
    else $error("output enabled outside a read");
  a_oe_holds_frame: assert property (so_oe_o && !cs_n_i |=> so_oe_o)
    else $error("output enable dropped inside frame");
endmodule : discovery_reader_assertions

bind discovery_reader discovery_reader_assertions chk (
  .clk_sys_i      (clk_sys_i),
  .rst_n_i        (rst_n_i),
  .cs_n_i         (cs_n_i),
  .sck_i          (sck_i),
  .so_o           (so_o),
  .so_oe_o        (so_oe_o),
  .frame_active_o (frame_active_o),
  .unique_read_o  (unique_read_o),
  .table_read_o   (table_read_o),
  .unknown_cmd_o  (unknown_cmd_o),
  .table_addr_o   (table_addr_o)
);

/* File: dv/spi_host_model.sv */
`timescale 1ns/1ps
module spi_host_model (
  input  wire logic       clk_sys_i,
  output logic            cs_n_o,
  output logic            sck_o,
  output logic            si_o,
  input  wire logic       so_i,
  output logic            rx_valid_o,
  output logic      [7:0] rx_byte_o
);
  logic [7:0] sh = 8'h00;

  initial begin
    cs_n_o = 1'b1;
    sck_o = 1'b0;
    si_o = 1'b0;
    rx_valid_o = 1'b0;
    rx_byte_o = 8'h00;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Half period of 2 clk, the fastest the device must follow
  task automatic xfer_bit(input logic b);
    @(posedge clk_sys_i);
    #1;
    rx_valid_o = 1'b0;
    @(posedge clk_sys_i);
    #1;
    sck_o = 1'b0;
    si_o = b;
    repeat (2) @(posedge clk_sys_i);
    #1;
    sck_o = 1'b1;
    sh = {sh[6:0], so_i};
  endtask : xfer_bit

  // Header bytes left aligned in hdr; tail bits cut a byte short
  task automatic frame(input logic [7:0] op, input logic [31:0] hdr,
                       input int nhdr, input int ndata, input int tail);
    repeat (2) @(posedge clk_sys_i);
    #1;
    cs_n_o = 1'b0;
    for (int i = 0; i < 8; i++) xfer_bit(op[7-i]);
    for (int i = 0; i < nhdr * 8; i++) xfer_bit(hdr[31-i]);
    for (int j = 0; j < ndata; j++) begin
      for (int i = 0; i < 8; i++) xfer_bit(i[0]);
      rx_valid_o = 1'b1;
      rx_byte_o = sh;
    end
    for (int i = 0; i < tail; i++) xfer_bit(i[1]);
  endtask : frame

  // Clock left high; si no longer holds its last value
  task automatic release_cs();
    @(posedge clk_sys_i);
    #1;
    rx_valid_o = 1'b0;
    @(posedge clk_sys_i);
    #1;
    cs_n_o = 1'b1;
    si_o = ~si_o;
    repeat (2) @(posedge clk_sys_i);
    #1;
  endtask : release_cs
endmodule : spi_host_model

/* File: dv/tb_top.sv */
`timescale 1ns/1ps
`include "discovery_reader_defines.svh"
module tb_top;
  // Arbitrary values, no real part or maker
  localparam logic [127:0] UID = 128'hC3A50F1E2D3C4B5A69788796A5B4C3D2;
  localparam logic [7:0]   VID = 8'h3C;
  logic             clk_sys_i = 1'b0;
  logic             rst_n_i = 1'b0;
  logic             cs_n, sck, si, so, so_oe, uniq, tbl_rd, unk, rxv;
  logic       [7:0] rxb;
  logic       [7:0] expq[$];
  logic       [7:0] lo[24] = '{8'h53, 8'h46, 8'h44, 8'h50, 8'h00, 8'h01,
    8'h01, 8'hFF, 8'h00, 8'h00, 8'h01, 8'h09, 8'h30, 8'h00, 8'h00, 8'hFF,
    VID, 8'h00, 8'h01, 8'h03, 8'h60, 8'h00, 8'h00, 8'hFF};
  logic       [7:0] hi[12] = '{8'hE5, 8'h20, 8'hF1, 8'hFF, 8'hFF, 8'hFF,
    8'hFF, 8'h00, 8'h44, 8'hEB, 8'h08, 8'h6B};
  int               mismatches = 0;
  int               checks = 0;
  int               a, n;

  always #5 clk_sys_i = ~clk_sys_i;

  discovery_reader #(.UNIQUE_NUMBER(UID), .VENDOR_ID(VID), .FIFO_DEPTH(4)) dut (
    .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .ce_i(1'b1), .cs_n_i(cs_n),
    .sck_i(sck), .si_i(si), .so_o(so), .so_oe_o(so_oe), .frame_active_o(),
    .unique_read_o(uniq), .table_read_o(tbl_rd), .unknown_cmd_o(unk),
    .table_addr_o());

  spi_host_model host (.clk_sys_i(clk_sys_i), .cs_n_o(cs_n), .sck_o(sck),
    .si_o(si), .so_i(so), .rx_valid_o(rxv), .rx_byte_o(rxb));

  ////////////////////////////////////////////////////////////////////////////
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp

  task automatic close_out();
    $display("checks=%0d mismatches=%0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : close_out

  // Unlisted addresses read as fill
  function automatic logic [7:0] tbl(input logic [23:0] ad);
    if (ad < 24'h18) return lo[ad[4:0]];
    if (ad[23:4] == 20'h3 && ad[3:0] < 4'hC) return hi[ad[3:0]];
    return 8'hFF;
  endfunction : tbl

  task automatic table_read(input logic [23:0] ad, input int nb, input int t);
    for (int i = 0; i < nb; i++) expq.push_back(tbl(ad + 24'(i)));
    host.frame(`DISCOVERY_TABLE_READ_OPCODE, {ad, 8'h00}, 4, nb, t);
    cmp({4'h0, so_oe, uniq, tbl_rd, unk}, 8'h0A);
    host.release_cs();
    cmp({6'h0, so_oe, so}, 8'h01);
  endtask : table_read

  task automatic unique_read(input int nb);
    for (int i = 0; i < nb; i++)
      expq.push_back(i < 16 ? UID[127-8*i -: 8] : 8'hFF);
    host.frame(`UNIQUE_NUMBER_READ_OPCODE, 32'h0, 4, nb, 0);
    cmp({4'h0, so_oe, uniq, tbl_rd, unk}, 8'h0C);
    host.release_cs();
    cmp({6'h0, so_oe, so}, 8'h01);
  endtask : unique_read

  // Byte checker: one note off the queue per byte seen
  always @(posedge clk_sys_i) begin
    if (rxv === 1'b1) begin
      if (expq.size() == 0) cmp(rxb, 8'hXX);
      else cmp(rxb, expq.pop_front());
    end
  end

  initial begin
    repeat (100000) @(posedge clk_sys_i);
    mismatches++;
    close_out();
  end

  initial begin
    void'($urandom(32'h71d64d16));
    repeat (4) @(posedge clk_sys_i);
    #1;
    rst_n_i = 1'b1;
    table_read(24'h000000, 24, 0);
    table_read(24'h000030, 12, 0);
    unique_read(18);
    unique_read(16);
    table_read(24'h000018, 3, 0);
    table_read(24'h400000, 2, 0);
    host.frame(8'h03, 32'h0, 0, 0, 16);
    cmp({4'h0, so_oe, uniq, tbl_rd, unk}, 8'h01);
    host.release_cs();
    // Random starts and lengths, cut 0 to 7 bits past the last whole byte
    for (int k = 0; k < 6; k++) begin
      a = $urandom_range(0, 23);
      n = $urandom_range(1, 24 - a);
      table_read(24'(a), n, $urandom_range(0, 7));
    end
    cmp(8'(expq.size()), 8'h00);
    close_out();
  end
endmodule : tb_top
